// >>> logic/smb_supply_monitor.sv
`timescale 1ns/1ns
module smb_supply_monitor (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire smb_pkg::smb_cmp_type         cmp_i,
  input  wire logic                         debug_pin_i,
  input  wire logic                         bootstrap_init_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire logic [smb_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [smb_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                         ucode_boost_wr_i,
  input  wire logic [smb_pkg::BOOST_W-1:0]  ucode_boost_data_i,
  input  wire logic                         irq_clear_i,
  output logic [smb_pkg::DATA_W-1:0]        reg_rdata_o,
  output logic                              reg_rvalid_o,
  output smb_pkg::smb_drv_type              drv_en_o,
  output logic                              interrupt_request_n_o,
  output logic                              power_on_reset_n_o,
  output logic                              gate_regulator_en_o,
  output logic [smb_pkg::BAT_W-1:0]         battery_dac_o,
  output logic [smb_pkg::BAT_W-1:0]         battery_level_o,
  output logic [smb_pkg::BAT_UV_W-1:0]      battery_uv_o,
  output logic [smb_pkg::BOOST_W-1:0]       boost_ref_o,
  output logic                              boost_above_target_o,
  output logic                              boost_low_flag_o
);
  import smb_pkg::*;

  typedef enum logic [3:0] {
    POR_OK     = 4'b0001,
    POR_WATCH  = 4'b0010,
    POR_DELAY  = 4'b0100,
    POR_ACTIVE = 4'b1000
  } smb_por_type;

  typedef enum logic [2:0] {
    SAR_LOAD   = 3'b001,
    SAR_SETTLE = 3'b010,
    SAR_DECIDE = 3'b100
  } smb_sar_type;

  smb_cmp_type                cmp_meta_q;
  smb_cmp_type                cmp_q;
  logic                       dbg_meta_q;
  logic                       dbg_q;
  logic                       boot_meta_q;
  logic                       boot_q;
  smb_por_type                por_state_q;
  logic [CNT_W-1:0]           por_cnt_q;
  logic                       por_active;
  logic                       rst_int;
  logic [CFG_FIELDS-1:0]      cfg_q;
  logic                       main_low_d1_q;
  logic                       irq_pend_q;
  logic [FILT_LEN-1:0]        filt_hist_q;
  logic                       boost_filt_q;
  logic                       boost_low;
  smb_sar_type                sar_state_q;
  logic [$clog2(BAT_W)-1:0]   sar_idx_q;
  logic [BAT_W-1:0]           sar_acc_q;
  logic [CNT_W-1:0]           settle_cnt_q;

  // comparator and pin levels come from outside this clock domain
  always_ff @(posedge clk_i)
  begin
    cmp_meta_q  <= cmp_i;
    cmp_q       <= cmp_meta_q;
    dbg_meta_q  <= debug_pin_i;
    dbg_q       <= dbg_meta_q;
    boot_meta_q <= bootstrap_init_i;
    boot_q      <= boot_meta_q;
  end

  // core supply watch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_state_q <= POR_OK;
      por_cnt_q   <= '0;
    end
    else
    begin
      unique case (por_state_q)
        POR_OK:
        begin
          por_cnt_q <= '0;
          if (cmp_q.core_low)
            por_state_q <= POR_WATCH;
        end
        POR_WATCH:
        begin
          if (!cmp_q.core_low)
            por_state_q <= POR_OK;
          else if (por_cnt_q == CNT_W'(POR_MIN_CYC - 1))
          begin
            por_state_q <= POR_DELAY;
            por_cnt_q   <= '0;
          end
          else
            por_cnt_q <= por_cnt_q + 1'b1;
        end
        POR_DELAY:
        begin
          if (por_cnt_q == CNT_W'(POR_DELAY_CYC - 1))
          begin
            por_state_q <= POR_ACTIVE;
            por_cnt_q   <= '0;
          end
          else
            por_cnt_q <= por_cnt_q + 1'b1;
        end
        POR_ACTIVE:
          if (!cmp_q.core_low)
            por_state_q <= POR_OK;
        default:
          por_state_q <= POR_OK;
      endcase
    end
  end

  assign por_active         = (por_state_q == POR_ACTIVE);
  assign rst_int            = rst_i | por_active;
  assign power_on_reset_n_o = !por_active;

  // register writes, offsets as printed
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
    begin
      cfg_q       <= CFG_RST;
      boost_ref_o <= BOOST_REF_RST;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == DRV_CFG2_ADDR)
        cfg_q <= reg_wdata_i[CFG_FIELDS-1:0];
      // register side wins over a microcode write in the same cycle
      if (reg_wr_i && reg_addr_i == BOOST_REF_ADDR)
        boost_ref_o <= reg_wdata_i[BOOST_W-1:0];
      else if (ucode_boost_wr_i)
        boost_ref_o <= ucode_boost_data_i;
    end
  end

  // register reads, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
    begin
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        if (reg_addr_i == DRV_CFG2_ADDR)
          reg_rdata_o <= DATA_W'(cfg_q);
        else if (reg_addr_i == BOOST_REF_ADDR)
          reg_rdata_o <= DATA_W'(boost_ref_o);
        else
          reg_rdata_o <= '0;
      end
    end
  end

  // 5 V undervoltage interrupt, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
    begin
      main_low_d1_q <= 1'b0;
      irq_pend_q    <= 1'b0;
    end
    else
    begin
      main_low_d1_q <= cmp_q.main_low;
      if (cmp_q.main_low && !main_low_d1_q)
        irq_pend_q <= 1'b1;
      else if (irq_clear_i)
        irq_pend_q <= 1'b0;
    end
  end

  assign interrupt_request_n_o = !(irq_pend_q && cfg_q[CFG_IRQ_EN]);

  // boost filter, shared by target and undervoltage modes
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
    begin
      filt_hist_q  <= '0;
      boost_filt_q <= 1'b0;
    end
    else
    begin
      filt_hist_q <= {filt_hist_q[FILT_LEN-2:0], cmp_q.boost_above};
      if (&filt_hist_q)
        boost_filt_q <= 1'b1;
      else if (~|filt_hist_q)
        boost_filt_q <= 1'b0;
    end
  end

  assign boost_above_target_o = boost_filt_q;
  assign boost_low = !cfg_q[CFG_BOOST_MON] && !boost_filt_q;
  assign boost_low_flag_o = boost_low;

  // pre-driver enables
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
      drv_en_o <= '0;
    else
    begin
      drv_en_o.ls <= !(cmp_q.main_low || cmp_q.gate_low
                       || (boost_low && cfg_q[CFG_BOOST_DIS]));
      drv_en_o.hs <= !(cmp_q.main_low || cmp_q.gate_low
                       || cmp_q.boost_uvlo
                       || (boost_low && cfg_q[CFG_BOOST_DIS]));
    end
  end

  // internal gate-supply regulator enable
  always_ff @(posedge clk_i)
  begin
    if (por_active)
      gate_regulator_en_o <= 1'b0;
    else if (rst_i || boot_q)
      gate_regulator_en_o <= dbg_q || !cfg_q[CFG_EXT_SEL];
    else
      gate_regulator_en_o <= !cfg_q[CFG_EXT_SEL];
  end

  // battery successive approximation, runs without end
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
    begin
      sar_state_q     <= SAR_LOAD;
      sar_idx_q       <= ($clog2(BAT_W))'(BAT_W - 1);
      sar_acc_q       <= '0;
      settle_cnt_q    <= '0;
      battery_dac_o   <= '0;
      battery_level_o <= '0;
    end
    else
    begin
      unique case (sar_state_q)
        SAR_LOAD:
        begin
          battery_dac_o <= sar_acc_q | (BAT_W'(1) << sar_idx_q);
          settle_cnt_q  <= '0;
          sar_state_q   <= SAR_SETTLE;
        end
        SAR_SETTLE:
        begin
          if (settle_cnt_q == CNT_W'(SETTLE_CYC - 1))
            sar_state_q <= SAR_DECIDE;
          else
            settle_cnt_q <= settle_cnt_q + 1'b1;
        end
        SAR_DECIDE:
        begin
          sar_state_q <= SAR_LOAD;
          if (sar_idx_q == '0)
          begin
            battery_level_o <= cmp_q.bat_above ? battery_dac_o
                                               : sar_acc_q;
            sar_acc_q       <= '0;
            sar_idx_q       <= ($clog2(BAT_W))'(BAT_W - 1);
          end
          else
          begin
            if (cmp_q.bat_above)
              sar_acc_q <= battery_dac_o;
            sar_idx_q <= sar_idx_q - 1'b1;
          end
        end
        default:
          sar_state_q <= SAR_LOAD;
      endcase
    end
  end

  // battery threshold of the latest code in microvolts
  always_ff @(posedge clk_i)
  begin
    if (rst_int)
      battery_uv_o <= '0;
    else
      battery_uv_o <= BAT_UV_W'(battery_level_o) * BAT_STEP_UV;
  end

  // checks
  sequence s_core_low_min;
    por_state_q == POR_WATCH && cmp_q.core_low
      && por_cnt_q == CNT_W'(POR_MIN_CYC - 1);
  endsequence
  sequence s_sar_last;
    sar_state_q == SAR_DECIDE && sar_idx_q == '0;
  endsequence

  a_main_low_off: assert property (@(posedge clk_i) disable iff (rst_int)
    cmp_q.main_low |=> !drv_en_o.hs && !drv_en_o.ls)
    else $error("drivers on during 5 V undervoltage");
  a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_int)
    cmp_q.main_low && !main_low_d1_q && cfg_q[CFG_IRQ_EN]
      |=> !interrupt_request_n_o)
    else $error("interrupt not raised on 5 V undervoltage");
  a_por_after_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    s_core_low_min |=> por_state_q == POR_DELAY
      ##(POR_DELAY_CYC) por_active)
    else $error("power-on reset delay wrong");
  a_por_reg_off: assert property (@(posedge clk_i) disable iff (rst_i)
    por_active |=> !gate_regulator_en_o)
    else $error("regulator on during power-on reset");
  a_ext_sel_off: assert property (@(posedge clk_i) disable iff (rst_int)
    !boot_q && cfg_q[CFG_EXT_SEL] |=> !gate_regulator_en_o)
    else $error("regulator on with external select");
  a_boot_dbg_on: assert property (@(posedge clk_i) disable iff (rst_int)
    boot_q && dbg_q |=> gate_regulator_en_o)
    else $error("regulator off in bootstrap with debug pin high");
  a_gate_low_off: assert property (@(posedge clk_i) disable iff (rst_int)
    cmp_q.gate_low |=> !drv_en_o.hs && !drv_en_o.ls)
    else $error("drivers on during gate supply undervoltage");
  a_boost_uvlo_hs: assert property (@(posedge clk_i) disable iff (rst_int)
    cmp_q.boost_uvlo |=> !drv_en_o.hs)
    else $error("high side on below boost lockout");
  a_boost_write: assert property (@(posedge clk_i) disable iff (rst_int)
    reg_wr_i && reg_addr_i == BOOST_REF_ADDR
      |=> boost_ref_o == $past(reg_wdata_i[BOOST_W-1:0]))
    else $error("boost reference write lost");
  a_sar_result: assert property (@(posedge clk_i) disable iff (rst_int)
    s_sar_last ##0 cmp_q.bat_above
      |=> battery_level_o == $past(battery_dac_o))
    else $error("battery result not latched");
  a_boost_flag: assert property (@(posedge clk_i) disable iff (rst_int)
    !cfg_q[CFG_BOOST_MON] && filt_hist_q == '0
      |=> boost_low_flag_o)
    else $error("boost low flag missing");

endmodule : smb_supply_monitor

// >>> logic/smb_pkg.sv
package smb_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // core supply watch: least time low, then delay to reset
  localparam int unsigned T_POR_MIN_NS   = 10000;
  localparam int unsigned T_POR_DELAY_NS = 5000;
  localparam int unsigned POR_MIN_CYC    =
    (T_POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_DELAY_CYC  =
    (T_POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // battery comparator settling per approximation step
  localparam int unsigned T_SETTLE_NS = 2000;
  localparam int unsigned SETTLE_CYC  =
    (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned BAT_W        = 6;
  localparam int unsigned BOOST_W      = 8;
  localparam int unsigned FILT_LEN     = 4;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned BAT_UV_W     = 26;
  // dac step 39.06 mV times divider 16, in microvolts
  localparam int unsigned BAT_LSB_UV   = 39060;
  localparam int unsigned BAT_DIV      = 16;
  localparam logic [BAT_UV_W-1:0] BAT_STEP_UV =
    BAT_UV_W'(BAT_LSB_UV * BAT_DIV);

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] BOOST_REF_ADDR = 9'h17f;
  localparam logic [ADDR_W-1:0] DRV_CFG2_ADDR  = 9'h1a6;

  // driver configuration two fields
  localparam int unsigned CFG_EXT_SEL   = 0;
  localparam int unsigned CFG_BOOST_MON = 1;
  localparam int unsigned CFG_BOOST_DIS = 2;
  localparam int unsigned CFG_IRQ_EN    = 3;
  localparam int unsigned CFG_FIELDS    = 4;
  localparam logic [CFG_FIELDS-1:0] CFG_RST  = 4'h3;
  localparam logic [BOOST_W-1:0] BOOST_REF_RST = 8'h00;

  typedef struct packed {
    logic main_low;
    logic core_low;
    logic gate_low;
    logic boost_uvlo;
    logic boost_above;
    logic bat_above;
  } smb_cmp_type;

  typedef struct packed {
    logic hs;
    logic ls;
  } smb_drv_type;

endpackage : smb_pkg

// >>> bench/smb_bat_model.sv
`timescale 1ns/1ns
module smb_bat_model (
  input  wire logic [smb_pkg::BAT_W-1:0] dac_i,
  input  wire logic [smb_pkg::BAT_W-1:0] level_i,
  output logic                           above_o
);
  import smb_pkg::*;
  // battery at or above the trial threshold keeps the bit
  assign above_o = (level_i >= dac_i);
endmodule : smb_bat_model

// >>> bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import smb_pkg::*;
  typedef struct packed {
    logic [4:0] cmp;
    logic [3:0] cfg;
    logic [1:0] drv;
    logic       flag;
    logic       above;
    logic       reg_en;
  } smb_row_type;
  logic                clk_i, rst_i, dbg, boot, wr, rd, uwr, iclr;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata, rdata;
  logic [BOOST_W-1:0]  udata, bref;
  logic [BAT_W-1:0]    dac, lvl, bat_lvl;
  logic [BAT_UV_W-1:0] bat_uv;
  logic [4:0]          cmp5;
  logic                bat_above, rvalid, irq_n, por_n, reg_en, above, flag;
  smb_cmp_type         cmp;
  smb_drv_type         drv;
  smb_row_type         rows [7];
  logic [BAT_W-1:0]    levels [3];
  int                  miscompares, checked;

  assign cmp = {cmp5, bat_above};

  smb_supply_monitor dut (
    .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp), .debug_pin_i(dbg),
    .bootstrap_init_i(boot), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .ucode_boost_wr_i(uwr),
    .ucode_boost_data_i(udata), .irq_clear_i(iclr), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .drv_en_o(drv), .interrupt_request_n_o(irq_n),
    .power_on_reset_n_o(por_n), .gate_regulator_en_o(reg_en),
    .battery_dac_o(dac), .battery_level_o(bat_lvl), .battery_uv_o(bat_uv),
    .boost_ref_o(bref), .boost_above_target_o(above),
    .boost_low_flag_o(flag)
  );

  smb_bat_model bat (.dac_i(dac), .level_i(lvl), .above_o(bat_above));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(negedge clk_i);
    rd = 1'b1;
    addr = a;
    @(negedge clk_i);
    rd = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask : reg_rd

  task do_reset(input logic d);
    dbg = d;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(reg_en, d);
    chk(drv, 2'b00);
    chk(irq_n, 1'b1);
    rst_i = 1'b0;
  endtask : do_reset

  task wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_cyc

  initial
  begin
    repeat (6000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  initial
  begin
    {boot, wr, rd, uwr, iclr} = 5'h00;
    addr = '0;
    wdata = '0;
    udata = '0;
    lvl = 6'h16;
    cmp5 = 5'h01;
    miscompares = 0;
    checked = 0;
    rows = '{'{5'h01, 4'h3, 2'h3, 1'b0, 1'b1, 1'b0},
             '{5'h11, 4'h3, 2'h0, 1'b0, 1'b1, 1'b0},
             '{5'h05, 4'h3, 2'h0, 1'b0, 1'b1, 1'b0},
             '{5'h03, 4'h3, 2'h1, 1'b0, 1'b1, 1'b0},
             '{5'h00, 4'h4, 2'h0, 1'b1, 1'b0, 1'b1},
             '{5'h00, 4'h0, 2'h3, 1'b1, 1'b0, 1'b1},
             '{5'h01, 4'h4, 2'h3, 1'b0, 1'b1, 1'b1}};
    levels = '{6'h08, 6'h16, 6'h39};
    do_reset(1'b1);
    reg_rd(DRV_CFG2_ADDR, 16'h0003);
    chk(dac, 6'h20);
    reg_rd(BOOST_REF_ADDR, 16'h0000);
    foreach (rows[i])
    begin
      reg_wr(DRV_CFG2_ADDR, {12'h000, rows[i].cfg});
      cmp5 = rows[i].cmp;
      wait_cyc(10);
      chk(drv, rows[i].drv);
      chk(flag, rows[i].flag);
      chk(above, rows[i].above);
      chk(reg_en, rows[i].reg_en);
      chk(irq_n, 1'b1);
    end
    // pending kept from the low row shows once the request is enabled
    reg_wr(DRV_CFG2_ADDR, 16'hfff9);
    reg_rd(DRV_CFG2_ADDR, 16'h0009);
    chk(irq_n, 1'b0);
    @(negedge clk_i);
    iclr = 1'b1;
    @(negedge clk_i);
    iclr = 1'b0;
    chk(irq_n, 1'b1);
    cmp5 = 5'h11;
    wait_cyc(4);
    chk(irq_n, 1'b0);
    chk(drv, 2'b00);
    @(negedge clk_i);
    iclr = 1'b1;
    @(negedge clk_i);
    iclr = 1'b0;
    chk(irq_n, 1'b1);
    cmp5 = 5'h01;
    reg_wr(BOOST_REF_ADDR, 16'hffa5);
    reg_rd(BOOST_REF_ADDR, 16'h00a5);
    // microcode strobe held through a register write to the same target
    @(negedge clk_i);
    uwr = 1'b1;
    udata = 8'h3c;
    @(negedge clk_i);
    chk(bref, 8'h3c);
    reg_wr(BOOST_REF_ADDR, 16'h005a);
    uwr = 1'b0;
    chk(bref, 8'h5a);
    reg_wr(9'h100, 16'h00ff);
    reg_rd(9'h100, 16'h0000);
    reg_rd(BOOST_REF_ADDR, 16'h005a);
    foreach (levels[i])
    begin
      lvl = levels[i];
      wait_cyc(300);
      chk(bat_lvl, levels[i]);
      chk(bat_uv, levels[i] * 26'd624960);
    end
    // bootstrap phase with the regulator owned by the pin
    reg_wr(DRV_CFG2_ADDR, 16'h0001);
    {dbg, boot} = 2'b11;
    wait_cyc(5);
    chk(reg_en, 1'b1);
    dbg = 1'b0;
    reg_wr(DRV_CFG2_ADDR, 16'h0000);
    wait_cyc(4);
    chk(reg_en, 1'b1);
    boot = 1'b0;
    reg_wr(DRV_CFG2_ADDR, 16'h0001);
    wait_cyc(4);
    chk(reg_en, 1'b0);
    do_reset(1'b0);
    boot = 1'b1;
    wait_cyc(5);
    chk(reg_en, 1'b0);
    boot = 1'b0;
    reg_wr(BOOST_REF_ADDR, 16'h0077);
    reg_wr(DRV_CFG2_ADDR, 16'h0000);
    cmp5 = 5'h09;
    wait_cyc(140);
    chk(por_n, 1'b1);
    wait_cyc(25);
    chk(por_n, 1'b0);
    chk(reg_en, 1'b0);
    chk(drv, 2'b00);
    cmp5 = 5'h01;
    wait_cyc(5);
    chk(por_n, 1'b1);
    reg_rd(DRV_CFG2_ADDR, 16'h0003);
    reg_rd(BOOST_REF_ADDR, 16'h0000);
    complete_run();
  end
endmodule : testbench
